// ---- include/ldwd_defs.vh ----
// register map, reset values and timing constants of the load wear diagnosis check
`ifndef LDWD_DEFS_VH
`define LDWD_DEFS_VH
`define LDWD_ADDR_W          5
`define LDWD_OFF_DYN_UP      5'h00
`define LDWD_OFF_DYN_LO      5'h01
`define LDWD_OFF_VISC_UP     5'h02
`define LDWD_OFF_VISC_LO     5'h03
`define LDWD_OFF_SPD_SET     5'h04
`define LDWD_OFF_TQ_TIME     5'h05
`define LDWD_OFF_TQ_UP       5'h06
`define LDWD_OFF_TQ_LO       5'h07
`define LDWD_OFF_FUNC_EXP    5'h08
`define LDWD_OFF_COIN_W      5'h09
`define LDWD_OFF_STATUS      5'h0A
`define LDWD_OFF_MASK        5'h0B
`define LDWD_OFF_TQ_AVG      5'h0C
`define LDWD_FUNC_DIAG_BIT   1
`define LDWD_RST_LIMIT       16'h0000
`define LDWD_RST_SPD_SET     16'h0000
`define LDWD_RST_COIN_W      16'h0032
`define LDWD_RST_FUNC_EXP    16'h0000
`define LDWD_ST_DYN          0
`define LDWD_ST_VISC         1
`define LDWD_ST_TQ           2
`define LDWD_ST_SPD          3
`define LDWD_ST_W            4
`define LDWD_MS_NS           1000000
`define LDWD_CLK_NS          40
`define LDWD_MS_CYC          (`LDWD_MS_NS / `LDWD_CLK_NS)
`define LDWD_MS_CNT_W        15
`define LDWD_MS_LAST         15'h61A7
`endif

// ---- src/ldwd_check.v ----
// load wear diagnosis check: limit judgments, speed window and torque average
`include "ldwd_defs.vh"
module ldwd_check (
    input  wire                     clk_sys,
    input  wire                     rst_n,
    input  wire [`LDWD_ADDR_W-1:0]  reg_addr,
    input  wire [15:0]              reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [15:0]              reg_rdata,
    input  wire                     est_converged,
    input  wire signed [15:0]       dyn_friction_est,
    input  wire [15:0]              visc_friction_est,
    input  wire signed [15:0]       motor_speed,
    input  wire signed [15:0]       torque_cmd,
    output reg                      diag_speed_window_out,
    output reg                      diag_warn,
    output reg                      irq
);

    reg signed [15:0] dyn_friction_upper_limit_r;
    reg signed [15:0] dyn_friction_lower_limit_r;
    reg        [15:0] visc_friction_upper_limit_r;
    reg        [15:0] visc_friction_lower_limit_r;
    reg signed [15:0] diag_speed_setpoint_r;
    reg        [15:0] torque_average_time_r;
    reg signed [15:0] torque_avg_upper_limit_r;
    reg signed [15:0] torque_avg_lower_limit_r;
    reg        [15:0] function_expansion_word_r;
    reg        [15:0] speed_coincidence_width_r;
    wire [`LDWD_ST_W-1:0] status_r;
    reg [`LDWD_ST_W-1:0] mask_r;
    reg signed [15:0] tq_avg_r;
    reg signed [47:0] tq_acc_r;
    reg        [15:0] ms_done_r;
    reg [`LDWD_MS_CNT_W-1:0] ms_cnt_r;
    reg               tq_valid_r;

    wire diag_en = function_expansion_word_r[`LDWD_FUNC_DIAG_BIT];

    // speed window, widened to avoid overflow at the ends of the range
    wire signed [17:0] spd_lo = {{2{diag_speed_setpoint_r[15]}}, diag_speed_setpoint_r}
                              - $signed({2'b00, speed_coincidence_width_r});
    wire signed [17:0] spd_hi = {{2{diag_speed_setpoint_r[15]}}, diag_speed_setpoint_r}
                              + $signed({2'b00, speed_coincidence_width_r});
    wire signed [17:0] spd_x  = {{2{motor_speed[15]}}, motor_speed};
    wire in_win = diag_en && (spd_x >= spd_lo) && (spd_x <= spd_hi);

    // estimates are trusted only once the estimator has settled
    wire est_ok      = diag_en && est_converged;
    wire tq_judge_en = diag_en && diag_speed_window_out && tq_valid_r;
    wire dyn_bad;
    wire visc_bad;
    wire tq_bad;

    // one comparator per judged quantity keeps the three judgments identical
    ldwd_lim_cmp #(
        .IS_SIGNED    (1)
    ) ldwd_lim_cmp_dyn_i (
        .judge_en     (est_ok),
        .value        (dyn_friction_est),
        .upper        (dyn_friction_upper_limit_r),
        .lower        (dyn_friction_lower_limit_r),
        .out_of_range (dyn_bad)
    );

    ldwd_lim_cmp #(
        .IS_SIGNED    (0)
    ) ldwd_lim_cmp_visc_i (
        .judge_en     (est_ok),
        .value        (visc_friction_est),
        .upper        (visc_friction_upper_limit_r),
        .lower        (visc_friction_lower_limit_r),
        .out_of_range (visc_bad)
    );

    ldwd_lim_cmp #(
        .IS_SIGNED    (1)
    ) ldwd_lim_cmp_tq_i (
        .judge_en     (tq_judge_en),
        .value        (tq_avg_r),
        .upper        (torque_avg_upper_limit_r),
        .lower        (torque_avg_lower_limit_r),
        .out_of_range (tq_bad)
    );

    // one tick per millisecond; there is no faster tick, so long averages
    // take their full programmed time in any test as well
    wire ms_tick = (ms_cnt_r == `LDWD_MS_LAST);

    // averaging: sum once per millisecond tick, divide when the time elapses;
    // a time of zero takes the current command directly
    wire signed [47:0] tq_acc_nxt = tq_acc_r + {{32{torque_cmd[15]}}, torque_cmd};
    wire [15:0]        ms_done_nxt = ms_done_r + 16'h0001;
    wire signed [47:0] tq_div = tq_acc_nxt / $signed({32'h0, ms_done_nxt});

    // status events, one bit each
    wire win_entered = in_win && !diag_speed_window_out;
    wire [`LDWD_ST_W-1:0] ev;
    assign ev[`LDWD_ST_DYN]  = dyn_bad;
    assign ev[`LDWD_ST_VISC] = visc_bad;
    assign ev[`LDWD_ST_TQ]   = tq_bad;
    assign ev[`LDWD_ST_SPD]  = win_entered;
    wire st_clr_wr = reg_wr && (reg_addr == `LDWD_OFF_STATUS);

    // a status bit is set by its event and cleared by writing a one
    genvar gi;
    generate
        for (gi = 0; gi < `LDWD_ST_W; gi = gi + 1) begin : g_status
            ldwd_sticky_bit ldwd_sticky_bit_i (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .set_ev  (ev[gi]),
                .clr_req (st_clr_wr && reg_wdata[gi]),
                .flag_r  (status_r[gi])
            );
        end
    endgenerate

    // registered window; its rising edge marks entry into the window
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            diag_speed_window_out <= 1'b0;
        end else begin
            diag_speed_window_out <= in_win;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_r    <= {`LDWD_MS_CNT_W{1'b0}};
            tq_acc_r    <= 48'sh0;
            ms_done_r   <= 16'h0000;
            tq_valid_r  <= 1'b0;
            tq_avg_r    <= 16'sh0;
        end else begin
            if (!in_win) begin
                // leaving the window restarts the average from scratch
                ms_cnt_r   <= {`LDWD_MS_CNT_W{1'b0}};
                tq_acc_r   <= 48'sh0;
                ms_done_r  <= 16'h0000;
                tq_valid_r <= 1'b0;
            end else if (torque_average_time_r == 16'h0000) begin
                tq_avg_r   <= torque_cmd;
                tq_valid_r <= 1'b1;
            end else if (ms_tick) begin
                ms_cnt_r <= {`LDWD_MS_CNT_W{1'b0}};
                if (ms_done_nxt >= torque_average_time_r) begin
                    tq_avg_r   <= tq_div[15:0];
                    tq_valid_r <= 1'b1;
                    tq_acc_r   <= 48'sh0;
                    ms_done_r  <= 16'h0000;
                end else begin
                    tq_acc_r  <= tq_acc_nxt;
                    ms_done_r <= ms_done_nxt;
                end
            end else begin
                ms_cnt_r <= ms_cnt_r + {{(`LDWD_MS_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dyn_friction_upper_limit_r  <= `LDWD_RST_LIMIT;
            dyn_friction_lower_limit_r  <= `LDWD_RST_LIMIT;
            visc_friction_upper_limit_r <= `LDWD_RST_LIMIT;
            visc_friction_lower_limit_r <= `LDWD_RST_LIMIT;
            diag_speed_setpoint_r       <= `LDWD_RST_SPD_SET;
            torque_average_time_r       <= `LDWD_RST_LIMIT;
            torque_avg_upper_limit_r    <= `LDWD_RST_LIMIT;
            torque_avg_lower_limit_r    <= `LDWD_RST_LIMIT;
            function_expansion_word_r   <= `LDWD_RST_FUNC_EXP;
            speed_coincidence_width_r   <= `LDWD_RST_COIN_W;
            mask_r                      <= {`LDWD_ST_W{1'b0}};
        end else begin
            if (reg_wr) begin
                if (reg_addr == `LDWD_OFF_DYN_UP) begin
                    dyn_friction_upper_limit_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_DYN_LO) begin
                    dyn_friction_lower_limit_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_VISC_UP) begin
                    visc_friction_upper_limit_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_VISC_LO) begin
                    visc_friction_lower_limit_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_SPD_SET) begin
                    diag_speed_setpoint_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_TQ_TIME) begin
                    torque_average_time_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_TQ_UP) begin
                    torque_avg_upper_limit_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_TQ_LO) begin
                    torque_avg_lower_limit_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_FUNC_EXP) begin
                    function_expansion_word_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_COIN_W) begin
                    speed_coincidence_width_r <= reg_wdata;
                end else if (reg_addr == `LDWD_OFF_MASK) begin
                    mask_r <= reg_wdata[`LDWD_ST_W-1:0];
                end
            end
        end
    end

    // flags registered so every output leaves straight from a flip-flop
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            diag_warn <= 1'b0;
            irq       <= 1'b0;
        end else begin
            diag_warn <= dyn_bad | visc_bad | tq_bad;
            irq       <= |(status_r & mask_r);
        end
    end

    // read data stand one cycle, then fall back to zero;
    // unmapped indices read as zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                if (reg_addr == `LDWD_OFF_DYN_UP) begin
                    reg_rdata <= dyn_friction_upper_limit_r;
                end else if (reg_addr == `LDWD_OFF_DYN_LO) begin
                    reg_rdata <= dyn_friction_lower_limit_r;
                end else if (reg_addr == `LDWD_OFF_VISC_UP) begin
                    reg_rdata <= visc_friction_upper_limit_r;
                end else if (reg_addr == `LDWD_OFF_VISC_LO) begin
                    reg_rdata <= visc_friction_lower_limit_r;
                end else if (reg_addr == `LDWD_OFF_SPD_SET) begin
                    reg_rdata <= diag_speed_setpoint_r;
                end else if (reg_addr == `LDWD_OFF_TQ_TIME) begin
                    reg_rdata <= torque_average_time_r;
                end else if (reg_addr == `LDWD_OFF_TQ_UP) begin
                    reg_rdata <= torque_avg_upper_limit_r;
                end else if (reg_addr == `LDWD_OFF_TQ_LO) begin
                    reg_rdata <= torque_avg_lower_limit_r;
                end else if (reg_addr == `LDWD_OFF_FUNC_EXP) begin
                    reg_rdata <= function_expansion_word_r;
                end else if (reg_addr == `LDWD_OFF_COIN_W) begin
                    reg_rdata <= speed_coincidence_width_r;
                end else if (reg_addr == `LDWD_OFF_STATUS) begin
                    reg_rdata <= {{(16-`LDWD_ST_W){1'b0}}, status_r};
                end else if (reg_addr == `LDWD_OFF_MASK) begin
                    reg_rdata <= {{(16-`LDWD_ST_W){1'b0}}, mask_r};
                end else if (reg_addr == `LDWD_OFF_TQ_AVG) begin
                    reg_rdata <= tq_avg_r;
                end
            end
        end
    end

endmodule

// one write-one-to-clear status bit; an event in the clearing cycle wins
module ldwd_sticky_bit (
    input  wire clk_sys,
    input  wire rst_n,
    input  wire set_ev,
    input  wire clr_req,
    output reg  flag_r
);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (set_ev) begin
            flag_r <= 1'b1;
        end else if (clr_req) begin
            flag_r <= 1'b0;
        end
    end
endmodule

// judges one quantity against an upper and a lower limit
module ldwd_lim_cmp #(
    parameter IS_SIGNED = 1
) (
    input  wire        judge_en,
    input  wire [15:0] value,
    input  wire [15:0] upper,
    input  wire [15:0] lower,
    output wire        out_of_range
);
    // one extra bit lets one signed compare serve signed and unsigned limits
    wire signed [16:0] value_x = IS_SIGNED ? {value[15], value} : {1'b0, value};
    wire signed [16:0] upper_x = IS_SIGNED ? {upper[15], upper} : {1'b0, upper};
    wire signed [16:0] lower_x = IS_SIGNED ? {lower[15], lower} : {1'b0, lower};

    assign out_of_range = judge_en && ((value_x > upper_x) || (value_x < lower_x));
endmodule

// ---- verif/ldwd_check_tb.sv ----
// self-checking bench of the load wear diagnosis check
`include "ldwd_defs.vh"
module ldwd_check_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, est_converged = 0, rd_q = 0;
    logic [`LDWD_ADDR_W-1:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, visc_friction_est = 0, exp_q[$];
    logic signed [15:0] dyn_friction_est = 16'h0005, motor_speed = 16'h1000, torque_cmd = 0;
    logic diag_speed_window_out, diag_warn, irq;
    int bad_count = 0, checked = 0;
    always #20 clk_sys = ~clk_sys;
    ldwd_check ldwd_check_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .est_converged(est_converged), .dyn_friction_est(dyn_friction_est),
        .visc_friction_est(visc_friction_est), .motor_speed(motor_speed),
        .torque_cmd(torque_cmd), .diag_speed_window_out(diag_speed_window_out),
        .diag_warn(diag_warn), .irq(irq));
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // flags are taken when fl is called, on the edge before its updates land; the #1 only delays the compare
    task automatic fl(input logic e, input logic g);
        #1 cmp({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic finish_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) rd_q <= reg_rd;
    always @(negedge clk_sys) if (rd_q) cmp(reg_rdata, exp_q.pop_front());
    initial begin
        #4000000 bad_count++;
        finish_test();
    end
    initial begin
        logic [15:0] off;
        void'($urandom(32'h755ede8a));
        idle(8);
        rst_n <= 1;
        for (int i = 0; i < 12; i++) rd(i[4:0], i == 9 ? `LDWD_RST_COIN_W : 16'h0000);
        rd(5'h1F, 16'h0000);
        est_converged <= 1;
        idle(4);
        rd(`LDWD_OFF_STATUS, 16'h0000);
        wr(`LDWD_OFF_FUNC_EXP, 16'h0002);
        idle(4);
        rd(`LDWD_OFF_STATUS, 16'h0001);
        fl(1, diag_warn);
        wr(`LDWD_OFF_DYN_UP, 16'h0064);
        wr(`LDWD_OFF_DYN_LO, 16'hFF9C);
        dyn_friction_est <= 16'hFF9B;
        est_converged <= 0;
        wr(`LDWD_OFF_STATUS, 16'h0001);
        idle(4);
        rd(`LDWD_OFF_STATUS, 16'h0000);
        est_converged <= 1;
        idle(4);
        rd(`LDWD_OFF_STATUS, 16'h0001);
        dyn_friction_est <= 16'h0064;
        wr(`LDWD_OFF_STATUS, 16'h0001);
        idle(4);
        fl(0, diag_warn);
        visc_friction_est <= 16'h2711;
        wr(`LDWD_OFF_VISC_UP, 16'h2710);
        wr(`LDWD_OFF_VISC_LO, 16'h0010);
        idle(4);
        rd(`LDWD_OFF_STATUS, 16'h0002);
        visc_friction_est <= 16'h2710;
        wr(`LDWD_OFF_STATUS, 16'h0002);
        idle(4);
        fl(0, diag_warn);
        fl(0, irq);
        wr(`LDWD_OFF_TQ_UP, 16'h0064);
        wr(`LDWD_OFF_TQ_LO, 16'hFF9C);
        torque_cmd <= 16'h00C8;
        wr(`LDWD_OFF_SPD_SET, 16'hFC18);
        motor_speed <= 16'hFC4A;
        idle(4);
        fl(1, diag_speed_window_out);
        rd(`LDWD_OFF_TQ_AVG, 16'h00C8);
        rd(`LDWD_OFF_STATUS, 16'h000C);
        repeat (4) begin
            off = 16'($urandom_range(100));
            motor_speed <= 16'hFBE6 + off;
            idle(3);
            fl(1, diag_speed_window_out);
        end
        motor_speed <= 16'hFC4B;
        idle(3);
        fl(0, diag_speed_window_out);
        wr(`LDWD_OFF_STATUS, 16'h000F);
        idle(3);
        rd(`LDWD_OFF_STATUS, 16'h0000);
        wr(`LDWD_OFF_TQ_TIME, 16'h0002);
        torque_cmd <= 16'h0032;
        motor_speed <= 16'hFC18;
        idle(52000);
        rd(`LDWD_OFF_TQ_AVG, 16'h0032);
        rd(`LDWD_OFF_STATUS, 16'h0008);
        wr(`LDWD_OFF_MASK, 16'h0001);
        dyn_friction_est <= 16'hFF9B;
        idle(4);
        fl(1, irq);
        dyn_friction_est <= 16'h0000;
        wr(`LDWD_OFF_STATUS, 16'h0009);
        idle(3);
        fl(0, irq);
        wr(`LDWD_OFF_FUNC_EXP, 16'h0000);
        idle(3);
        fl(0, diag_speed_window_out);
        finish_test();
    end
endmodule

// ---- verif/ldwd_checker.sv ----
// port assertions of the load wear diagnosis check
`include "ldwd_defs.vh"
module ldwd_checker (
    input wire                    clk_sys,
    input wire                    rst_n,
    input wire [`LDWD_ADDR_W-1:0] reg_addr,
    input wire [15:0]             reg_wdata,
    input wire                    reg_wr,
    input wire                    reg_rd,
    input wire [15:0]             reg_rdata,
    input wire                    est_converged,
    input wire signed [15:0]      motor_speed,
    input wire                    diag_speed_window_out,
    input wire                    diag_warn,
    input wire                    irq
);
    logic diag_en_m;
    // mirror of the diagnosis enable bit, taken from the write bus
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) diag_en_m <= 1'b0;
        else if (reg_wr && reg_addr == `LDWD_OFF_FUNC_EXP) diag_en_m <= reg_wdata[1];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    rd_unmapped_a: assert property (reg_rd && reg_addr > 5'h0C |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    status_rsvd_a: assert property (reg_rd && reg_addr == 5'h0A |=> reg_rdata[15:4] == 12'h000)
        else $error("status reserved bits set");
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("irq fell without a write");
    // status is sticky, so nothing can raise irq while every cause is absent
    irq_quiet_a: assert property ((!est_converged && !diag_speed_window_out && !reg_wr) [*3]
        |=> !$rose(irq)) else $error("irq rose with no cause");
    warn_cause_a: assert property ((!est_converged && !diag_speed_window_out) [*3]
        |=> !diag_warn) else $error("warning without convergence or window");
    win_change_a: assert property ($changed(diag_speed_window_out) |-> $past(reg_wr)
        || $past(reg_wr, 2) || $past(reg_wr, 3) || $past(motor_speed) != $past(motor_speed, 2))
        else $error("window moved with speed and settings still");
    win_enable_a: assert property (diag_speed_window_out |-> $past(diag_en_m))
        else $error("window output while diagnosis disabled");
    warn_enable_a: assert property (diag_warn |-> $past(diag_en_m))
        else $error("warning while diagnosis disabled");
endmodule
bind ldwd_check ldwd_checker ldwd_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .est_converged(est_converged), .motor_speed(motor_speed),
    .diag_speed_window_out(diag_speed_window_out), .diag_warn(diag_warn), .irq(irq));
